// *** design/stpd_top.sv ***
// system timer, peripheral control port and board address decoder
`timescale 1ns/1ns
`default_nettype none
module stpd_top
    import stpd_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire stpd_io_req_t IO_REQ,
    input wire logic [23:0] MEM_ADDR,
    input wire logic SHADOW_EN,
    output logic [7:0] IO_RDATA,
    output logic IO_RACK,
    output logic IO_SYSBOARD,
    output logic IO_EXPANSION,
    output logic COPRO_BUSY_CLR,
    output logic COPRO_RESET,
    output logic COPRO_SEL,
    output stpd_mem_sel_t MEM_SEL,
    output logic IRQ0_OUT,
    output logic REFRESH_REQ,
    output logic SPEAKER_OUT
);
    ////////////////////////////////////////////////////////////////////////
    // timer oscillator enable
    logic [7:0] tick_cnt_r;
    logic [7:0] tick_cnt_nxt;
    logic tmr_tick_r;
    wire logic tick_wrap = (tick_cnt_r == TICK_DIV_LAST);

    assign tick_cnt_nxt = tick_wrap ? 8'h00 : tick_cnt_r + 8'h01;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            tick_cnt_r <= 8'h00;
            tmr_tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tmr_tick_r <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // i/o address decode
    wire logic io_act = IO_REQ.wr || IO_REQ.rd;
    wire logic [9:0] addr = IO_REQ.addr;
    wire logic dec_sys = stpd_in_io(addr, IO_SYS_LO, IO_SYS_HI);
    wire logic dec_exp = stpd_in_io(addr, IO_EXP_LO, IO_EXP_HI);
    wire logic dec_tmr = stpd_in_io(addr, IO_TMR_LO, IO_TMR_HI);
    wire logic [1:0] tmr_idx = addr[1:0];
    wire logic dec_pctl = (addr == IO_PCTL);
    wire logic dec_cclr = (addr == IO_COPRO_CLR);
    wire logic dec_crst = (addr == IO_COPRO_RST);
    wire logic dec_cprt = stpd_in_io(addr, IO_COPRO_LO, IO_COPRO_HI);

    wire logic tmr_ctrl_we = IO_REQ.wr && dec_tmr && (tmr_idx == TMR_CTRL_IDX);
    wire logic [1:0] ctrl_sel = IO_REQ.wdata[SEL_HI:SEL_LO];

    ////////////////////////////////////////////////////////////////////////
    // peripheral control port
    logic [1:0] pctl_r;
    logic [1:0] pctl_nxt;

    assign pctl_nxt = (IO_REQ.wr && dec_pctl) ? IO_REQ.wdata[1:0] : pctl_r;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST)
            pctl_r <= PCTL_RESET;
        else
            pctl_r <= pctl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // counter channels
    logic [2:0] ch_out;
    logic [2:0] ch_gate;
    logic [7:0] ch_rdata [3];

    assign ch_gate[0] = 1'b1;
    assign ch_gate[1] = 1'b1;
    // channel 2 gate from port bit 0
    assign ch_gate[2] = pctl_r[PCTL_GATE2];

    for (genvar i = 0; i < 3; i++) begin : g_ch
        stpd_counter u_cnt (
            .clk(CORE_CLK),
            .nrst(NRST),
            .tick(tmr_tick_r),
            .gate(ch_gate[i]),
            .ctrl_we(tmr_ctrl_we && (ctrl_sel == 2'(i))),
            .ctrl(IO_REQ.wdata),
            .data_we(IO_REQ.wr && dec_tmr && (tmr_idx == 2'(i))),
            .data_rd(IO_REQ.rd && dec_tmr && (tmr_idx == 2'(i))),
            .wdata(IO_REQ.wdata),
            .rdata(ch_rdata[i]),
            .out(ch_out[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    wire logic [7:0] pctl_rd = {2'h0, ch_out[2], 3'h0, pctl_r};
    wire logic [7:0] tmr_rd = (tmr_idx == TMR_CTRL_IDX) ? RDATA_IDLE :
        ch_rdata[tmr_idx];
    wire logic [7:0] rdata_nxt = dec_tmr ? tmr_rd :
        dec_pctl ? pctl_rd : RDATA_IDLE;
    wire logic rack_nxt = IO_REQ.rd && (dec_tmr || dec_pctl);

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            IO_RDATA <= RDATA_IDLE;
            IO_RACK <= 1'b0;
        end else begin
            IO_RDATA <= rack_nxt ? rdata_nxt : RDATA_IDLE;
            IO_RACK <= rack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // i/o decode outputs
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            IO_SYSBOARD <= 1'b0;
            IO_EXPANSION <= 1'b0;
            COPRO_BUSY_CLR <= 1'b0;
            COPRO_RESET <= 1'b0;
            COPRO_SEL <= 1'b0;
        end else begin
            IO_SYSBOARD <= io_act && dec_sys;
            IO_EXPANSION <= io_act && dec_exp;
            COPRO_BUSY_CLR <= io_act && dec_cclr;
            COPRO_RESET <= io_act && dec_crst;
            COPRO_SEL <= io_act && dec_cprt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory decode
    // display buffer window
    wire logic mem_disp = stpd_in_mem(MEM_ADDR, MEM_DISP_LO, MEM_DISP_HI);
    wire logic mem_romw = stpd_in_mem(MEM_ADDR, MEM_ROM_LO, MEM_ROM_HI);
    stpd_mem_sel_t mem_nxt;

    assign mem_nxt.display = mem_disp;
    assign mem_nxt.rom = mem_romw && !SHADOW_EN;
    assign mem_nxt.shadow = mem_romw && SHADOW_EN;
    assign mem_nxt.board = !mem_disp && !mem_romw;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST)
            MEM_SEL <= '0;
        else
            MEM_SEL <= mem_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // counter outputs
    logic ch1_d_r;
    wire logic ch1_rise = ch_out[1] && !ch1_d_r;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ch1_d_r <= 1'b0;
            REFRESH_REQ <= 1'b0;
            IRQ0_OUT <= 1'b0;
            SPEAKER_OUT <= 1'b0;
        end else begin
            ch1_d_r <= ch_out[1];
            REFRESH_REQ <= ch1_rise;
            IRQ0_OUT <= ch_out[0];
            SPEAKER_OUT <= ch_out[2];
        end
    end
endmodule
`default_nettype wire

// *** shared/stpd_pkg.sv ***
// shared constants, types and helpers of the system timer and port decoder
package stpd_pkg;
    // clock rates and timer oscillator divider
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_KHZ = 1190;
    localparam int unsigned TICK_DIV = CLK_HZ / (TICK_KHZ * 1000);
    localparam logic [7:0] TICK_DIV_LAST = 8'(TICK_DIV - 1);
    // i/o map
    localparam logic [9:0] IO_SYS_LO = 10'h000;
    localparam logic [9:0] IO_SYS_HI = 10'h0ff;
    localparam logic [9:0] IO_EXP_LO = 10'h100;
    localparam logic [9:0] IO_EXP_HI = 10'h3ff;
    localparam logic [9:0] IO_TMR_LO = 10'h040;
    localparam logic [9:0] IO_TMR_HI = 10'h05f;
    localparam logic [9:0] IO_PCTL = 10'h061;
    localparam logic [9:0] IO_COPRO_CLR = 10'h0f0;
    localparam logic [9:0] IO_COPRO_RST = 10'h0f1;
    localparam logic [9:0] IO_COPRO_LO = 10'h0f8;
    localparam logic [9:0] IO_COPRO_HI = 10'h0ff;
    localparam logic [1:0] TMR_CTRL_IDX = 2'h3;
    // memory map
    localparam logic [23:0] MEM_DISP_LO = 24'h0a0000;
    localparam logic [23:0] MEM_DISP_HI = 24'h0bffff;
    localparam logic [23:0] MEM_ROM_LO = 24'h0c0000;
    localparam logic [23:0] MEM_ROM_HI = 24'h0fffff;
    // timer control word fields
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int RW_HI = 5;
    localparam int RW_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 1;
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB = 2'h1;
    localparam logic [1:0] RW_MSB = 2'h2;
    localparam logic [1:0] RW_BOTH = 2'h3;
    localparam logic [2:0] MODE_TC = 3'h0;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    // peripheral control port fields and reset value
    localparam int PCTL_GATE2 = 0;
    localparam int PCTL_SPKEN = 1;
    localparam int PCTL_OUT2 = 5;
    localparam logic [1:0] PCTL_RESET = 2'h0;
    localparam logic [7:0] RDATA_IDLE = 8'hff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        CNT_IDLE = 3'b001,
        CNT_LOAD = 3'b010,
        CNT_RUN = 3'b100
    } stpd_cnt_state_t;

    typedef struct packed {
        logic [9:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } stpd_io_req_t;

    typedef struct packed {
        logic display;
        logic rom;
        logic shadow;
        logic board;
    } stpd_mem_sel_t;

    function automatic logic stpd_in_io(input logic [9:0] a,
        input logic [9:0] lo, input logic [9:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic stpd_in_mem(input logic [23:0] a,
        input logic [23:0] lo, input logic [23:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
endpackage

// *** design/stpd_counter.sv ***
// one programmable down-counter channel
`timescale 1ns/1ns
`default_nettype none
module stpd_counter
    import stpd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic gate,
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl,
    input wire logic data_we,
    input wire logic data_rd,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic out
);
    stpd_cnt_state_t state_r;
    logic [2:0] mode_r;
    logic [1:0] rw_r;
    logic [15:0] count_r;
    logic [15:0] reload_r;
    logic [15:0] latch_r;
    logic latched_r;
    logic wr_hi_r;
    logic rd_hi_r;
    logic out_r;

    wire logic [1:0] rw_in = ctrl[RW_HI:RW_LO];
    wire logic is_latch = ctrl_we && (rw_in == RW_LATCH);
    wire logic is_mode = ctrl_we && (rw_in != RW_LATCH);
    wire logic wr_done = data_we && ((rw_r != RW_BOTH) || wr_hi_r);
    wire logic [15:0] wr_val = (rw_r == RW_LSB) ? {8'h00, wdata} :
        (rw_r == RW_MSB) ? {wdata, 8'h00} :
        wr_hi_r ? {wdata, reload_r[7:0]} : {reload_r[15:8], wdata};
    wire logic [15:0] rd_src = latched_r ? latch_r : count_r;
    wire logic rd_sel_hi = (rw_r == RW_MSB) || ((rw_r == RW_BOTH) && rd_hi_r);
    wire logic [15:0] step = (mode_r == MODE_SQUARE) ? 16'h0002 : 16'h0001;
    wire logic at_end = (count_r <= step) && (count_r != COUNT_RESET);
    wire logic run = tick && gate && (state_r == CNT_RUN);

    assign rdata = rd_sel_hi ? rd_src[15:8] : rd_src[7:0];
    assign out = out_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_TC;
            rw_r <= RW_BOTH;
            reload_r <= COUNT_RESET;
            wr_hi_r <= 1'b0;
        end else if (is_mode) begin
            mode_r <= ctrl[MODE_HI:MODE_LO];
            rw_r <= rw_in;
            wr_hi_r <= 1'b0;
        end else if (data_we) begin
            reload_r <= wr_val;
            wr_hi_r <= (rw_r == RW_BOTH) && !wr_hi_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_r <= COUNT_RESET;
            latched_r <= 1'b0;
            rd_hi_r <= 1'b0;
        end else if (is_mode) begin
            latched_r <= 1'b0;
            rd_hi_r <= 1'b0;
        end else if (is_latch && !latched_r) begin
            latch_r <= count_r;
            latched_r <= 1'b1;
        end else if (data_rd) begin
            rd_hi_r <= (rw_r == RW_BOTH) && !rd_hi_r;
            if (!((rw_r == RW_BOTH) && !rd_hi_r))
                latched_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= CNT_IDLE;
            count_r <= COUNT_RESET;
            out_r <= 1'b0;
        end else if (is_mode) begin
            state_r <= CNT_IDLE;
            out_r <= (ctrl[MODE_HI:MODE_LO] != MODE_TC);
        end else begin
            case (state_r)
                CNT_IDLE: begin
                    if (wr_done)
                        state_r <= CNT_LOAD;
                end
                CNT_LOAD: begin
                    if (tick) begin
                        count_r <= reload_r;
                        state_r <= CNT_RUN;
                        if (mode_r == MODE_TC)
                            out_r <= 1'b0;
                    end
                end
                CNT_RUN: begin
                    if (wr_done && (mode_r == MODE_TC))
                        state_r <= CNT_LOAD;
                    else if (!gate && (mode_r != MODE_TC))
                        out_r <= 1'b1;
                    else if (run && at_end && (mode_r != MODE_TC)) begin
                        count_r <= reload_r;
                        out_r <= (mode_r == MODE_SQUARE) ? !out_r : 1'b1;
                    end else if (run) begin
                        count_r <= count_r - step;
                        if ((mode_r == MODE_TC) && (count_r == 16'h0001))
                            out_r <= 1'b1;
                        if ((mode_r != MODE_TC) && (count_r == 16'h0002))
                            out_r <= 1'b0;
                    end
                end
                default: state_r <= CNT_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verif/stpd_top_properties.sv ***
// port assertions of the timer and board decoder
`timescale 1ns/1ns
`default_nettype none
module stpd_top_properties
    import stpd_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire stpd_io_req_t IO_REQ,
    input wire logic [23:0] MEM_ADDR,
    input wire logic SHADOW_EN,
    input wire logic IO_RACK,
    input wire logic IO_SYSBOARD,
    input wire logic IO_EXPANSION,
    input wire logic COPRO_BUSY_CLR,
    input wire logic COPRO_RESET,
    input wire logic COPRO_SEL,
    input wire stpd_mem_sel_t MEM_SEL,
    input wire logic REFRESH_REQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    logic acc;
    assign acc = IO_REQ.wr | IO_REQ.rd;
    ////////////////////////////////////////////////
    a_sysboard_claim: assert property (acc && IO_REQ.addr <= 10'h0ff
        |=> IO_SYSBOARD && !IO_EXPANSION) else $error("board i/o unclaimed");
    a_expansion_fwd: assert property (acc && IO_REQ.addr >= 10'h100
        |=> IO_EXPANSION && !IO_SYSBOARD) else $error("i/o not forwarded");
    a_busy_clear: assert property (COPRO_BUSY_CLR
        |-> $past(acc && IO_REQ.addr == 10'h0f0)) else $error("stray clear");
    a_copro_reset: assert property (acc && IO_REQ.addr == 10'h0f1
        |=> COPRO_RESET && !COPRO_BUSY_CLR) else $error("no copro reset");
    a_copro_port: assert property (acc && IO_REQ.addr >= 10'h0f8
        && IO_REQ.addr <= 10'h0ff |=> COPRO_SEL)
        else $error("copro port not selected");
    a_display_map: assert property (
        MEM_ADDR inside {[24'h0a0000:24'h0bffff]}
        |=> MEM_SEL.display && !MEM_SEL.board && !MEM_SEL.rom)
        else $error("display buffer not selected");
    a_rom_map: assert property (MEM_ADDR inside {[24'h0c0000:24'h0fffff]}
        |=> MEM_SEL.rom == !$past(SHADOW_EN)
        && MEM_SEL.shadow == $past(SHADOW_EN))
        else $error("rom or shadow wrong");
    a_timer_ack: assert property (IO_REQ.rd && IO_REQ.addr >= 10'h040
        && IO_REQ.addr <= 10'h05f |=> IO_RACK)
        else $error("timer read unanswered");
    a_refresh_pulse: assert property (REFRESH_REQ
        |=> !REFRESH_REQ [*8]) else $error("refresh pulse too long");
endmodule
bind stpd_top stpd_top_properties chk_u (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .IO_REQ(IO_REQ), .MEM_ADDR(MEM_ADDR), .SHADOW_EN(SHADOW_EN),
    .IO_RACK(IO_RACK), .IO_SYSBOARD(IO_SYSBOARD), .IO_EXPANSION(IO_EXPANSION),
    .COPRO_BUSY_CLR(COPRO_BUSY_CLR), .COPRO_RESET(COPRO_RESET),
    .COPRO_SEL(COPRO_SEL), .MEM_SEL(MEM_SEL), .REFRESH_REQ(REFRESH_REQ));
`default_nettype wire

// *** verif/stpd_host_model.sv ***
// host processor model issuing system i/o cycles
`timescale 1ns/1ns
`default_nettype none
module stpd_host_model
    import stpd_pkg::*;
(
    input wire logic clk,
    output var stpd_io_req_t io_req
);
    initial io_req = '0;
    // one cycle taken at one edge, then the bus shows inverted junk
    task automatic io(input logic [9:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk);
        #1;
        io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// *** verif/test_system_timer_and_port_decode.sv ***
// self-checking bench of the timer and board decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("mismatch at %0t: check %0d", $time, n_compared); \
    end \
end
module test_system_timer_and_port_decode
    import stpd_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [23:0] mem_addr = 24'h000000;
    logic shadow_en = 1'b0;
    stpd_io_req_t io_req;
    stpd_mem_sel_t mem_sel;
    logic [7:0] io_rdata;
    logic io_rack, io_sys, io_exp, busy_clr, copro_rst, copro_sel;
    logic irq0, refresh, speaker;
    int err_count = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////
    stpd_host_model host_u (.clk(core_clk), .io_req(io_req));
    stpd_top dut_u (.CORE_CLK(core_clk), .NRST(nrst), .IO_REQ(io_req),
        .MEM_ADDR(mem_addr), .SHADOW_EN(shadow_en), .IO_RDATA(io_rdata),
        .IO_RACK(io_rack), .IO_SYSBOARD(io_sys), .IO_EXPANSION(io_exp),
        .COPRO_BUSY_CLR(busy_clr), .COPRO_RESET(copro_rst),
        .COPRO_SEL(copro_sel), .MEM_SEL(mem_sel), .IRQ0_OUT(irq0),
        .REFRESH_REQ(refresh), .SPEAKER_OUT(speaker));
    initial forever #4 core_clk = ~core_clk;
    ////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? irq0 : (s == 1 ? refresh : speaker);
    endfunction
    // count edges up to the next rise of a timer output
    task automatic rise(input int s, inout int n);
        logic prev;
        prev = sig(s);
        for (int k = 0; k < 4000; k++) begin
            @(posedge core_clk);
            #2;
            n++;
            if (sig(s) === 1'b1 && prev === 1'b0)
                return;
            prev = sig(s);
        end
        err_count++;
        $display("mismatch at %0t: no timer edge", $time);
        test_done();
    endtask
    task automatic gap(input int s, output int n);
        n = 0;
        rise(s, n);
        rise(s, n);
        n = 0;
        rise(s, n);
    endtask
    task automatic load(input logic [7:0] cw, input logic [9:0] p,
        input logic [7:0] lo);
        host_u.io(10'h043, 1'b1, cw);
        host_u.io(p, 1'b1, lo);
        host_u.io(p, 1'b1, 8'h00);
    endtask
    ////////////////////////////////////////////////
    task automatic t_io_decode();
        logic [9:0] tbl [13] = '{10'h000, 10'h020, 10'h040, 10'h043,
            10'h05f, 10'h061, 10'h0f0, 10'h0f1, 10'h0f8, 10'h0ff, 10'h100,
            10'h2f8, 10'h3ff};
        logic [9:0] a;
        for (int i = 0; i < 26; i++) begin
            a = tbl[i % 13];
            if (i >= 13 && a >= 10'h040 && a <= 10'h061)
                continue;
            host_u.io(a, i >= 13, 8'h00);
            `CHK(io_sys, a <= 10'h0ff)
            `CHK(io_exp, a >= 10'h100)
            `CHK(busy_clr, a == 10'h0f0)
            `CHK(copro_rst, a == 10'h0f1)
            `CHK(copro_sel, a >= 10'h0f8 && a <= 10'h0ff)
            `CHK(io_rack, i < 13 && a inside {[10'h040:10'h05f], 10'h061})
            if (a == 10'h000 || a == 10'h043)
                `CHK(io_rdata, RDATA_IDLE)
        end
    endtask
    task automatic t_mem_map();
        logic [23:0] tbl [6] = '{24'h09ffff, 24'h0a0000, 24'h0bffff,
            24'h0c0000, 24'h0fffff, 24'h100000};
        logic [23:0] a;
        logic rom;
        for (int i = 0; i < 12; i++) begin
            a = tbl[i % 6];
            @(posedge core_clk);
            #1;
            mem_addr = a;
            shadow_en = i >= 6;
            @(posedge core_clk);
            #2;
            rom = a >= 24'h0c0000 && a <= 24'h0fffff;
            `CHK(mem_sel.display, a >= 24'h0a0000 && a <= 24'h0bffff)
            `CHK(mem_sel.board, a < 24'h0a0000 || a > 24'h0fffff)
            `CHK(mem_sel.rom, rom && !shadow_en)
            `CHK(mem_sel.shadow, rom && shadow_en)
        end
    endtask
    task automatic t_timers();
        int n;
        int lows;
        lows = 0;
        load(8'h34, 10'h040, 8'h04);
        gap(0, n);
        `CHK(n, int'(4 * TICK_DIV))
        // channel 1 set for the 15 us refresh period
        load(8'h74, 10'h041, 8'd18);
        gap(1, n);
        `CHK(n, int'(18 * TICK_DIV))
        host_u.io(10'h061, 1'b1, 8'h00);
        load(8'hb6, 10'h042, 8'h04);
        for (int k = 0; k < 300; k++) begin
            @(posedge core_clk);
            #2;
            lows += (speaker !== 1'b1);
        end
        `CHK(lows, 0)
        // latch the held channel 2 count and read both bytes
        host_u.io(10'h043, 1'b1, 8'h80);
        host_u.io(10'h042, 1'b0, 8'h00);
        `CHK(io_rdata, 8'h04)
        host_u.io(10'h042, 1'b0, 8'h00);
        `CHK(io_rdata, 8'h00)
        host_u.io(10'h061, 1'b1, 8'h03);
        host_u.io(10'h061, 1'b0, 8'h00);
        `CHK(io_rack, 1'b1)
        `CHK(io_rdata[1:0], 2'b11)
        gap(2, n);
        `CHK(n, int'(4 * TICK_DIV))
    endtask
    ////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        t_io_decode();
        t_mem_map();
        t_timers();
        test_done();
    end
endmodule
`default_nettype wire
